// ==== sci_top.sv ====
/*
 * Host port target with strap configuration, power states and thermal
 * shutdown. Link logic runs on linkClk, a free-running oversampling clock
 * well above the bus rate; the rest runs on clk.
 * Assumes an outside pad model resolves the open-drain pins from the
 * enables and that the command logic answers each read request.
 */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Hold clock low after a byte until ready
// - Stretch around the acknowledge bit
// - After boot answer strap-selected address
// - Sub-address byte frames writes and reads
// - Latch straps at boot: address, power management
// - Second strap: min, max current, charging mode
// - Three power states, changed automatically
// - Idle only after quiet period without activity
// - Attach wakes the device from Sleep
// - Standby keeps source path, drops cable path
// - Die overheat disables functions until cooled
// - Path overheat disables all power paths
// - Path resumes by itself or by firmware
// - Acknowledge a matching address byte
// - Ack received bytes, release on master NACK
module sci_top #(
	parameter int QUIET_CYCLES = sci_pkg::IDLE_QUIET_CYCLES
) (
	// Core clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link oversampling clock
	input wire logic linkClk,
	// Host port pins, open drain
	input wire logic hostPortClockIn,
	output logic hostPortClockOut,
	output logic hostPortClockOeN,
	input wire logic hostPortDataIn,
	output logic hostPortDataOut,
	output logic hostPortDataOeN,
	// Straps and boot
	input wire logic [2:0] strapInputOne,
	input wire logic [2:0] strapInputTwo,
	input wire logic bootBusy,
	output sci_pkg::sci_cfg_t strapCfg,
	output logic bootDone,
	// Command side
	output logic hostWrStrobe,
	output logic hostWrFirst,
	output logic [7:0] hostWrData,
	output logic hostRdReq,
	input wire logic hostRdValid,
	input wire logic [7:0] hostRdData,
	// Activity sources and power state
	input wire logic ccChange,
	input wire logic gpioEvent,
	input wire logic voltAlert,
	input wire logic faultAlert,
	input wire logic needActive,
	input wire logic sleepAllowed,
	input wire logic attachDetect,
	input wire logic modernStandby,
	output sci_pkg::sci_pwr_t powerState,
	output logic sourcePathEn,
	output logic cablePathEn,
	output logic functionsEn,
	// Thermal comparators and policy
	input wire logic dieHot,
	input wire logic dieCool,
	input wire logic [1:0] pathHot,
	input wire logic pathCool,
	input wire logic autoResume,
	input wire logic fwReenable,
	output logic dieOff,
	output logic pathOff
);

	localparam int QW = $clog2(QUIET_CYCLES + 1);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic linkRst;
	logic [1:0] pinS;
	logic [2:0] linkCfgS;
	logic sclS;
	logic sdaS;
	logic sclP;
	logic sdaP;
	sci_pkg::sci_link_t st;
	logic [7:0] shift;
	logic [3:0] bitCnt;
	logic rw;
	logic first;
	logic reqTog;
	logic actTog;
	sci_pkg::sci_req_t linkReq;
	logic ackPulse;
	logic ackTog;
	logic rdWait;
	logic [7:0] rdHold;
	logic reqPulse;
	logic i2cAct;
	logic [5:0] strapS;
	logic [4:0] thermS;
	logic bootBusyP;
	sci_pkg::sci_cfg_t nextCfg;
	sci_pkg::sci_pwr_t next_pwr;
	logic [QW-1:0] quietCnt;

	// ----------------------------------------------------------------
	// Crossings
	// ----------------------------------------------------------------
	// Link reset follows core reset through two stages
	sci_sync2 #(.W(1)) u_rstSync (
		.clk(linkClk),
		.rst(1'b0),
		.d(rst),
		.q(linkRst)
	);

	// Bus pins come from outside both domains
	sci_sync2 #(.W(2)) u_pinSync (
		.clk(linkClk),
		.rst(1'b0),
		.d({hostPortClockIn, hostPortDataIn}),
		.q(pinS)
	);

	// Address index is static once boot completes; enable also drops with dieOff
	sci_sync2 #(.W(3)) u_cfgSync (
		.clk(linkClk),
		.rst(linkRst),
		.d({bootDone & ~dieOff, strapCfg.addrIdx}),
		.q(linkCfgS)
	);

	// Core answer back to the link
	sci_event_sync u_ackSync (
		.clk(linkClk),
		.rst(linkRst),
		.tog(ackTog),
		.pulse(ackPulse)
	);

	// Link request to the core; linkReq is stable while it waits
	sci_event_sync u_reqSync (
		.clk(clk),
		.rst(rst),
		.tog(reqTog),
		.pulse(reqPulse)
	);

	// Addressed transaction seen, counts as activity
	sci_event_sync u_actSync (
		.clk(clk),
		.rst(rst),
		.tog(actTog),
		.pulse(i2cAct)
	);

	// Async levels; strap copy survives reset for the boot latch
	sci_sync2 #(.W(6)) u_strapSync (
		.clk(clk),
		.rst(1'b0),
		.d({strapInputOne, strapInputTwo}),
		.q(strapS)
	);

	sci_sync2 #(.W(5)) u_thermSync (
		.clk(clk),
		.rst(rst),
		.d({dieHot, dieCool, pathHot, pathCool}),
		.q(thermS)
	);

	// ----------------------------------------------------------------
	// Link decode
	// ----------------------------------------------------------------
	wire linkEnable = linkCfgS[2];
	wire [6:0] myAddr = sci_pkg::ADDR_TABLE[linkCfgS[1:0]];
	wire sclRise = sclS & ~sclP;
	wire sclFall = ~sclS & sclP;
	wire startC = sclS & sclP & sdaP & ~sdaS;
	wire stopC = sclS & sclP & ~sdaP & sdaS;
	wire bitsDone = (bitCnt == sci_pkg::BYTE_BITS);
	wire txLast = (bitCnt == sci_pkg::TX_LAST);
	wire addrHit = (shift[7:1] == myAddr) & linkEnable;

	assign sclS = pinS[1];
	assign sdaS = pinS[0];

	// Previous pin levels for edge and condition detection
	always_ff @(posedge linkClk)
	begin
		if (linkRst)
		begin
			sclP <= 1'b1;
			sdaP <= 1'b1;
		end
		else
		begin
			sclP <= sclS;
			sdaP <= sdaS;
		end
	end

	// Pads only ever pull low
	always_ff @(posedge linkClk)
	begin
		hostPortClockOut <= 1'b0;
		hostPortDataOut <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Link engine
	// ----------------------------------------------------------------
	// Stretching starts only on a falling edge, so the line is already
	// low when we take it; a free clock edge is never cut short
	always_ff @(posedge linkClk)
	begin
		if (linkRst)
		begin
			st <= sci_pkg::SCI_L_IDLE;
			shift <= '0;
			bitCnt <= '0;
			rw <= 1'b0;
			first <= 1'b0;
			reqTog <= 1'b0;
			actTog <= 1'b0;
			linkReq <= '0;
			hostPortDataOeN <= 1'b1;
			hostPortClockOeN <= 1'b1;
		end
		else if (startC)
		begin
			st <= sci_pkg::SCI_L_ADDR;
			bitCnt <= '0;
			hostPortDataOeN <= 1'b1;
			hostPortClockOeN <= 1'b1;
		end
		else if (stopC)
		begin
			st <= sci_pkg::SCI_L_IDLE;
			hostPortDataOeN <= 1'b1;
			hostPortClockOeN <= 1'b1;
		end
		else
		begin
			case (st)
				sci_pkg::SCI_L_ADDR, sci_pkg::SCI_L_WRX:
				begin
					if (sclRise)
					begin
						shift <= {shift[6:0], sdaS};
						bitCnt <= bitCnt + 4'h1;
					end
					else if (sclFall && bitsDone && st == sci_pkg::SCI_L_ADDR)
					begin
						if (addrHit)
						begin
							hostPortDataOeN <= 1'b0;
							rw <= shift[0];
							first <= 1'b1;
							actTog <= ~actTog;
							st <= sci_pkg::SCI_L_ACK;
						end
						else
							st <= sci_pkg::SCI_L_IDLE;
					end
					else if (sclFall && bitsDone)
					begin
						// Sub-address travels as the first write byte
						linkReq <= '{read: 1'b0, first: first, data: shift};
						first <= 1'b0;
						reqTog <= ~reqTog;
						hostPortClockOeN <= 1'b0;
						st <= sci_pkg::SCI_L_WWAIT;
					end
				end
				sci_pkg::SCI_L_WWAIT:
				begin
					if (ackPulse)
					begin
						hostPortDataOeN <= 1'b0;
						hostPortClockOeN <= 1'b1;
						st <= sci_pkg::SCI_L_ACK;
					end
				end
				sci_pkg::SCI_L_ACK:
				begin
					if (sclFall)
					begin
						hostPortDataOeN <= 1'b1;
						bitCnt <= '0;
						if (rw)
						begin
							linkReq <= '{read: 1'b1, first: 1'b0, data: 8'h00};
							reqTog <= ~reqTog;
							hostPortClockOeN <= 1'b0;
							st <= sci_pkg::SCI_L_LOAD;
						end
						else
							st <= sci_pkg::SCI_L_WRX;
					end
				end
				sci_pkg::SCI_L_LOAD:
				begin
					if (ackPulse)
					begin
						shift <= rdHold;
						hostPortDataOeN <= rdHold[7];
						hostPortClockOeN <= 1'b1;
						bitCnt <= '0;
						st <= sci_pkg::SCI_L_TX;
					end
				end
				sci_pkg::SCI_L_TX:
				begin
					if (sclFall && txLast)
					begin
						hostPortDataOeN <= 1'b1;
						st <= sci_pkg::SCI_L_RACK;
					end
					else if (sclFall)
					begin
						hostPortDataOeN <= shift[6];
						shift <= {shift[6:0], 1'b0};
						bitCnt <= bitCnt + 4'h1;
					end
				end
				sci_pkg::SCI_L_RACK:
				begin
					// NACK leaves the data line free for the Stop
					if (sclRise)
						st <= sdaS ? sci_pkg::SCI_L_IDLE : sci_pkg::SCI_L_RGO;
				end
				sci_pkg::SCI_L_RGO:
				begin
					if (sclFall)
					begin
						linkReq <= '{read: 1'b1, first: 1'b0, data: 8'h00};
						reqTog <= ~reqTog;
						hostPortClockOeN <= 1'b0;
						st <= sci_pkg::SCI_L_LOAD;
					end
				end
				default:
				begin
					hostPortDataOeN <= 1'b1;
					hostPortClockOeN <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Command handshake, core side
	// ----------------------------------------------------------------
	// Write bytes are answered at once; reads wait for the command logic
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hostWrStrobe <= 1'b0;
			hostWrFirst <= 1'b0;
			hostWrData <= '0;
			hostRdReq <= 1'b0;
			rdWait <= 1'b0;
			rdHold <= '0;
			ackTog <= 1'b0;
		end
		else if (reqPulse)
		begin
			hostRdReq <= linkReq.read;
			rdWait <= linkReq.read;
			hostWrStrobe <= ~linkReq.read;
			hostWrData <= linkReq.data;
			hostWrFirst <= linkReq.first;
			ackTog <= linkReq.read ? ackTog : ~ackTog;
		end
		else
		begin
			hostWrStrobe <= 1'b0;
			hostRdReq <= 1'b0;
			if (rdWait && hostRdValid)
			begin
				rdHold <= hostRdData;
				rdWait <= 1'b0;
				ackTog <= ~ackTog;
			end
		end
	end

	// ----------------------------------------------------------------
	// Boot strap latch
	// ----------------------------------------------------------------
	assign nextCfg.simple_power_management = strapS[3 + sci_pkg::STRAP_ONE_SPM];
	assign nextCfg.addrIdx = strapS[4:3];
	assign nextCfg.minHigh = strapS[sci_pkg::STRAP_TWO_MIN] &
		strapS[3 + sci_pkg::STRAP_ONE_SPM];
	assign nextCfg.maxHigh = strapS[sci_pkg::STRAP_TWO_MAX];
	assign nextCfg.dcpAuto = strapS[sci_pkg::STRAP_TWO_DCP];
	wire bootFall = bootBusyP & ~bootBusy;

	// Latched once at the end of boot, never again
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bootBusyP <= 1'b1;
			bootDone <= 1'b0;
			strapCfg <= sci_pkg::CFG_RESET;
		end
		else
		begin
			bootBusyP <= bootBusy;
			if (bootFall && !bootDone)
			begin
				strapCfg <= nextCfg;
				bootDone <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Power states
	// ----------------------------------------------------------------
	wire activity = ccChange | gpioEvent | i2cAct | voltAlert | faultAlert;
	wire quietDone = (quietCnt == QW'(QUIET_CYCLES - 1));

	// Next power state
	always_comb
	begin
		next_pwr = powerState;
		case (powerState)
			sci_pkg::SCI_PWR_ACTIVE:
				if (quietDone && !activity && !needActive)
					next_pwr = sci_pkg::SCI_PWR_IDLE;
			sci_pkg::SCI_PWR_IDLE:
				if (activity || needActive)
					next_pwr = sci_pkg::SCI_PWR_ACTIVE;
				else if (sleepAllowed)
					next_pwr = sci_pkg::SCI_PWR_SLEEP;
			sci_pkg::SCI_PWR_SLEEP:
				if (attachDetect || activity || needActive)
					next_pwr = sci_pkg::SCI_PWR_ACTIVE;
			default:
				next_pwr = sci_pkg::SCI_PWR_ACTIVE;
		endcase
	end

	// Quiet counter restarts on any activity or outside Active
	always_ff @(posedge clk)
	begin
		if (rst || activity || powerState != sci_pkg::SCI_PWR_ACTIVE)
			quietCnt <= '0;
		else if (!quietDone)
			quietCnt <= quietCnt + QW'(1);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			powerState <= sci_pkg::SCI_PWR_ACTIVE;
		else
			powerState <= next_pwr;
	end

	// ----------------------------------------------------------------
	// Thermal shutdown and power paths
	// ----------------------------------------------------------------
	wire dieHotS = thermS[4];
	wire dieCoolS = thermS[3];
	wire pathHotS = |thermS[2:1];
	wire pathCoolS = thermS[0];
	wire pathsOk = ~pathOff & ~dieOff;

	// Hot wins over any release in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			dieOff <= 1'b0;
			pathOff <= 1'b0;
		end
		else
		begin
			if (dieHotS)
				dieOff <= 1'b1;
			else if (dieCoolS)
				dieOff <= 1'b0;
			if (pathHotS)
				pathOff <= 1'b1;
			else if (pathCoolS && (autoResume || fwReenable))
				pathOff <= 1'b0;
		end
	end

	// Standby keeps the source path but drops the cable path
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sourcePathEn <= 1'b0;
			cablePathEn <= 1'b0;
			functionsEn <= 1'b0;
		end
		else
		begin
			sourcePathEn <= pathsOk & (powerState != sci_pkg::SCI_PWR_SLEEP);
			cablePathEn <= pathsOk & ((powerState == sci_pkg::SCI_PWR_ACTIVE) |
				((powerState == sci_pkg::SCI_PWR_IDLE) & ~modernStandby));
			functionsEn <= ~dieOff;
		end
	end

endmodule

`default_nettype wire

// ==== sci_pkg.sv ====
/*
 * Shared constants and types for the strap-configured host port target
 * and its power and thermal supervisor.
 * Assumes a 20 MHz core clock; all users refer to names as sci_pkg::name.
 */
`default_nettype none

package sci_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 20;
	localparam int IDLE_QUIET_US = 1000;
	localparam int IDLE_QUIET_CYCLES = IDLE_QUIET_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Target addresses, one per strap address index
	// ----------------------------------------------------------------
	localparam logic [3:0][6:0] ADDR_TABLE = {7'h23, 7'h22, 7'h21, 7'h20};

	// ----------------------------------------------------------------
	// Strap field positions
	// ----------------------------------------------------------------
	localparam int STRAP_ONE_SPM = 2;
	localparam int STRAP_TWO_MIN = 2;
	localparam int STRAP_TWO_MAX = 1;
	localparam int STRAP_TWO_DCP = 0;

	// ----------------------------------------------------------------
	// Byte framing counts
	// ----------------------------------------------------------------
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] TX_LAST = 4'h7;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SCI_PWR_ACTIVE, SCI_PWR_IDLE, SCI_PWR_SLEEP}
		sci_pwr_t;

	typedef enum logic [3:0] {SCI_L_IDLE, SCI_L_ADDR, SCI_L_ACK, SCI_L_WRX,
		SCI_L_WWAIT, SCI_L_LOAD, SCI_L_TX, SCI_L_RACK, SCI_L_RGO} sci_link_t;

	typedef struct packed {
		logic simple_power_management;
		logic minHigh;
		logic maxHigh;
		logic dcpAuto;
		logic [1:0] addrIdx;
	} sci_cfg_t;

	typedef struct packed {
		logic read;
		logic first;
		logic [7:0] data;
	} sci_req_t;

	localparam sci_cfg_t CFG_RESET = '0;

endpackage

`default_nettype wire

// ==== sci_sync2.sv ====
/*
 * Two flip-flop level synchroniser of parameterised width.
 * Assumes the input is a level that stays put for several destination
 * clocks, or bits that change one at a time.
 */
`timescale 1ns/1ns
`default_nettype none

module sci_sync2 #(
	parameter int W = 1
) (
	// Destination clock and reset
	input wire logic clk,
	input wire logic rst,
	// Level in and synchronised level out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end

endmodule

`default_nettype wire

// ==== sci_event_sync.sv ====
/*
 * Toggle-to-pulse event crossing.
 * Assumes the source flips its toggle at most once per several
 * destination clocks; each flip gives one destination pulse.
 */
`timescale 1ns/1ns
`default_nettype none

module sci_event_sync (
	// Destination clock and reset
	input wire logic clk,
	input wire logic rst,
	// Toggle from the far domain and one-cycle pulse out
	input wire logic tog,
	output logic pulse
);

	logic meta;
	logic sync;
	logic prev;

	// Two stages, then an edge compare on the settled copy
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end
		else
		begin
			meta <= tog;
			sync <= meta;
			prev <= sync;
		end
	end

	assign pulse = sync ^ prev;

endmodule

`default_nettype wire

// ==== sci_top_properties.sv ====
/*
 * Port checks on sci_top, bound into every instance.
 * Assumes a core clock clk with synchronous active-high reset rst.
 */
`timescale 1ns/1ns
`default_nettype none

module sci_top_properties #(
	parameter int QUIET_CYCLES = 20
) (
	// Core clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pins, straps and command side
	input wire logic hostPortClockOut,
	input wire logic hostPortDataOut,
	input wire sci_pkg::sci_cfg_t strapCfg,
	input wire logic bootDone,
	input wire logic hostWrStrobe,
	input wire logic hostRdReq,
	// Activity and power
	input wire logic ccChange,
	input wire logic gpioEvent,
	input wire logic voltAlert,
	input wire logic faultAlert,
	input wire logic needActive,
	input wire logic attachDetect,
	input wire logic modernStandby,
	input wire sci_pkg::sci_pwr_t powerState,
	input wire logic sourcePathEn,
	input wire logic cablePathEn,
	input wire logic dieOff,
	input wire logic pathOff
);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	// Margin of two covers input registering inside the design
	localparam int QMIN = QUIET_CYCLES - 2;
	logic act, inAct, inIdle, inSleep;
	int quiet;
	assign act = ccChange | gpioEvent | voltAlert | faultAlert | needActive;
	assign inAct = powerState == sci_pkg::SCI_PWR_ACTIVE;
	assign inIdle = powerState == sci_pkg::SCI_PWR_IDLE;
	assign inSleep = powerState == sci_pkg::SCI_PWR_SLEEP;

	// Cycles since the last visible activity
	always_ff @(posedge clk)
		quiet <= (rst || act) ? 0 : quiet + 1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	pins_drive_low_a: assert property (
		!hostPortClockOut && !hostPortDataOut)
		else $error("pad data value not low");
	min_needs_spm_a: assert property (
		strapCfg.minHigh |-> strapCfg.simple_power_management)
		else $error("minimum current without power management");
	straps_frozen_a: assert property (
		bootDone |=> bootDone && $stable(strapCfg))
		else $error("straps moved after boot");
	wr_pulse_a: assert property (hostWrStrobe |=> !hostWrStrobe)
		else $error("write strobe too long");
	rd_pulse_a: assert property (hostRdReq |=> !hostRdReq)
		else $error("read request too long");
	quiet_idle_a: assert property (
		$past(inAct) && inIdle |-> quiet >= QMIN)
		else $error("idle before quiet period");
	no_skip_a: assert property (inAct |=> !inSleep)
		else $error("active went straight to sleep");
	idle_wake_a: assert property (
		inIdle && act |-> ##[1:3] inAct)
		else $error("activity did not wake idle");
	attach_wake_a: assert property (
		inSleep && attachDetect |-> ##[1:4] inAct)
		else $error("attach did not wake sleep");
	sleep_paths_a: assert property (
		inSleep |=> !sourcePathEn && !cablePathEn)
		else $error("power path on in sleep");
	standby_cable_a: assert property (
		inIdle && modernStandby |=> !cablePathEn)
		else $error("cable path on in standby");
	hot_paths_a: assert property (
		pathOff || dieOff |=> !sourcePathEn && !cablePathEn)
		else $error("power path on while shut down");

	// Main scenarios reached
	sleep_c: cover property (inSleep);
	write_c: cover property (hostWrStrobe);
	path_off_c: cover property (pathOff);
endmodule

bind sci_top sci_top_properties #(.QUIET_CYCLES(QUIET_CYCLES)) chk (.*);

`default_nettype wire

// ==== sci_i2c_master.sv ====
/*
 * Host port master model: start, stop and bytes.
 * Assumes the bench resolves both open-drain wires with pull-ups.
 */
`timescale 1ns/1ns
`default_nettype none

module sci_i2c_master #(
	parameter int Q = 500,
	parameter int THIGH = 4000
) (
	// Resolved wire levels
	input wire logic sclWire,
	input wire logic sdaWire,
	// Pull-downs, low pulls the wire
	output logic sclOeN,
	output logic sdaOeN
);
	// ----------------------------------------------------------------
	// Bus phases
	// ----------------------------------------------------------------
	// Both lines released at power-up
	initial
	begin
		sclOeN = 1'h1;
		sdaOeN = 1'h1;
	end

	// Release clock; a stretching target holds it low meanwhile
	task automatic clkHigh();
		#Q sclOeN = 1'h1;
		wait (sclWire === 1'h1);
		#THIGH;
	endtask

	// Also serves as repeated start after a byte
	task automatic start();
		#Q sdaOeN = 1'h1;
		clkHigh();
		sdaOeN = 1'h0;
		#Q sclOeN = 1'h0;
	endtask

	task automatic stop();
		#Q sdaOeN = 1'h0;
		clkHigh();
		sdaOeN = 1'h1;
		#Q;
	endtask

	task automatic bitIo(input logic b, output logic r);
		#Q sdaOeN = b;
		clkHigh();
		r = sdaWire;
		sclOeN = 1'h0;
	endtask

	// Eight bits MSB first, then the acknowledge bit
	task automatic xfer(input logic [7:0] tx, input logic last,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
			bitIo(tx[i], rx[i]);
		bitIo(last, ack);
	endtask
endmodule

`default_nettype wire

// ==== sci_top_bench.sv ====
/*
 * Self-checking bench for sci_top.
 * Assumes sci_pkg, the master model and the checker are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module sci_top_bench;
	// ----------------------------------------------------------------
	// Stimulus, wires and scoreboard
	// ----------------------------------------------------------------
	logic clk, linkClk, rst, hostRdValid, needActive, sleepAllowed;
	logic attachDetect, modernStandby, dieHot, dieCool, pathCool;
	logic autoResume, fwReenable, rdPend, sawStretch, bootBusy;
	logic [3:0] act;
	logic [1:0] pathHot;
	logic [2:0] strapInputOne, strapInputTwo;
	logic [7:0] hostRdData, rv;
	wire logic sclOeN, sdaOeN, mSclOeN, mSdaOeN, hostWrStrobe, hostWrFirst;
	wire logic hostRdReq, bootDone, sourcePathEn, cablePathEn, functionsEn;
	wire logic dieOff, pathOff;
	wire logic [7:0] hostWrData;
	sci_pkg::sci_cfg_t strapCfg;
	sci_pkg::sci_pwr_t powerState;
	// Wired-AND with pull-ups
	wire logic sclW = sclOeN & mSclOeN;
	wire logic sdaW = sdaOeN & mSdaOeN;
	int seed = 32'h6d40_2a58;
	int fails = 0;
	int total_checks = 0;
	logic [8:0] expWr[$];
	logic [7:0] rdSent[$];

	sci_top #(.QUIET_CYCLES(20)) dut (.clk(clk), .rst(rst), .linkClk(linkClk),
		.hostPortClockIn(sclW), .hostPortClockOut(), .hostPortClockOeN(sclOeN),
		.hostPortDataIn(sdaW), .hostPortDataOut(), .hostPortDataOeN(sdaOeN),
		.strapInputOne(strapInputOne), .strapInputTwo(strapInputTwo),
		.bootBusy(bootBusy), .strapCfg(strapCfg), .bootDone(bootDone),
		.hostWrStrobe(hostWrStrobe), .hostWrFirst(hostWrFirst),
		.hostWrData(hostWrData), .hostRdReq(hostRdReq),
		.hostRdValid(hostRdValid), .hostRdData(hostRdData),
		.ccChange(act[0]), .gpioEvent(act[1]), .voltAlert(act[2]),
		.faultAlert(act[3]), .needActive(needActive),
		.sleepAllowed(sleepAllowed), .attachDetect(attachDetect),
		.modernStandby(modernStandby), .powerState(powerState),
		.sourcePathEn(sourcePathEn), .cablePathEn(cablePathEn),
		.functionsEn(functionsEn), .dieHot(dieHot), .dieCool(dieCool),
		.pathHot(pathHot), .pathCool(pathCool), .autoResume(autoResume),
		.fwReenable(fwReenable), .dieOff(dieOff), .pathOff(pathOff));

	sci_i2c_master #(.Q(500), .THIGH(4000)) m (.sclWire(sclW),
		.sdaWire(sdaW), .sclOeN(mSclOeN), .sdaOeN(mSdaOeN));

	// Core clock 50 ns
	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// Link clock 80 ns, phase offset
	initial
	begin
		linkClk = 1'h0;
		#13;
		forever #40 linkClk = ~linkClk;
	end

	task automatic check(input string what, input logic [8:0] seen, exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Bounded wait for a power state
	task automatic waitPwr(input sci_pkg::sci_pwr_t s);
		for (int n = 0; n < 80 && powerState !== s; n++)
			@(posedge clk);
		check("pwr", 9'(powerState), 9'(s));
	endtask

	// Read answers two cycles after the request; writes against notes
	always @(posedge clk)
	begin
		rdPend <= hostRdReq;
		hostRdValid <= rdPend;
		if (rdPend)
		begin
			rv = 8'($random(seed));
			hostRdData <= rv;
			rdSent.push_back(rv);
		end
		if (hostWrStrobe)
			check("wr", {hostWrFirst, hostWrData}, expWr.pop_front());
		if (!sclOeN)
			sawStretch = 1'h1;
	end

	// Watchdog well above the expected run
	initial
	begin
		#4500000;
		fails++;
		tally_and_finish();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] r;
		logic [7:0] rx, sub;
		logic [6:0] adr;
		logic ak;
		{rst, hostRdValid, rdPend, act, pathHot} = 9'h100;
		{needActive, sleepAllowed, attachDetect, modernStandby} = 4'h0;
		{bootBusy, dieHot, dieCool, pathCool, autoResume, fwReenable} = 6'h20;
		{strapInputOne, strapInputTwo, hostRdData} = 14'h0;
		sawStretch = 1'h0;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			r = $random(seed);
			strapInputOne <= {r[2], 2'(i)};
			strapInputTwo <= r[5:3];
			rst <= 1'h1;
			bootBusy <= 1'h1;
			repeat (6) @(posedge clk);
			rst <= 1'h0;
			repeat (4) @(posedge clk);
			check("busy", 9'(bootDone), 9'h0);
			bootBusy <= 1'h0;
			repeat (6) @(posedge clk);
			check("cfg", 9'(strapCfg), 9'({r[2], r[5] & r[2], r[4:3], 2'(i)}));
			check("boot", 9'(bootDone), 9'h001);
			adr = sci_pkg::ADDR_TABLE[i];
			sub = r[15:8];
			sawStretch = 1'h0;
			expWr.push_back({1'h1, sub});
			expWr.push_back({1'h0, r[23:16]});
			m.start();
			m.xfer({adr, 1'h0}, 1'h1, rx, ak);
			check("adrAck", 9'(ak), 9'h000);
			m.xfer(sub, 1'h1, rx, ak);
			check("subAck", 9'(ak), 9'h000);
			m.xfer(r[23:16], 1'h1, rx, ak);
			check("datAck", 9'(ak), 9'h000);
			m.stop();
			check("stretch", 9'(sawStretch), 9'h001);
			m.start();
			m.xfer({adr ^ 7'h04, 1'h0}, 1'h1, rx, ak);
			check("badAdr", 9'(ak), 9'h001);
			m.stop();
			expWr.push_back({1'h1, sub});
			m.start();
			m.xfer({adr, 1'h0}, 1'h1, rx, ak);
			m.xfer(sub, 1'h1, rx, ak);
			m.start();
			m.xfer({adr, 1'h1}, 1'h1, rx, ak);
			check("rdAck", 9'(ak), 9'h000);
			for (int k = 0; k < 2; k++)
			begin
				m.xfer(8'hff, 1'(k), rx, ak);
				check("rdDat", 9'(rx), 9'(rdSent.pop_front()));
			end
			repeat (4) @(posedge linkClk);
			check("release", 9'(sdaOeN), 9'h001);
			m.stop();
		end
		check("wrLeft", 9'(expWr.size()), 9'h000);
		@(posedge clk);
		modernStandby <= 1'h1;
		for (int k = 0; k < 4; k++)
		begin
			waitPwr(sci_pkg::SCI_PWR_IDLE);
			repeat (2) @(posedge clk);
			check("stby", 9'({sourcePathEn, cablePathEn}), 9'h002);
			act <= 4'h1 << k;
			@(posedge clk);
			act <= 4'h0;
			repeat (12) @(posedge clk);
			check("stay", 9'(powerState), 9'(sci_pkg::SCI_PWR_ACTIVE));
		end
		sleepAllowed <= 1'h1;
		waitPwr(sci_pkg::SCI_PWR_SLEEP);
		repeat (2) @(posedge clk);
		check("slp", 9'({sourcePathEn, cablePathEn}), 9'h000);
		attachDetect <= 1'h1;
		waitPwr(sci_pkg::SCI_PWR_ACTIVE);
		@(posedge clk);
		attachDetect <= 1'h0;
		needActive <= 1'h1;
		pathHot <= 2'h2;
		repeat (6) @(posedge clk);
		check("pHot", 9'({pathOff, sourcePathEn, cablePathEn}), 9'h004);
		pathHot <= 2'h0;
		pathCool <= 1'h1;
		repeat (6) @(posedge clk);
		check("pHold", 9'(pathOff), 9'h001);
		fwReenable <= 1'h1;
		repeat (6) @(posedge clk);
		check("pFw", 9'({pathOff, sourcePathEn}), 9'h001);
		fwReenable <= 1'h0;
		pathHot <= 2'h1;
		autoResume <= 1'h1;
		repeat (6) @(posedge clk);
		check("pSet", 9'(pathOff), 9'h001);
		pathHot <= 2'h0;
		repeat (6) @(posedge clk);
		check("pAuto", 9'(pathOff), 9'h000);
		dieHot <= 1'h1;
		repeat (6) @(posedge clk);
		check("die", 9'({dieOff, functionsEn, sourcePathEn}), 9'h004);
		dieHot <= 1'h0;
		dieCool <= 1'h1;
		repeat (6) @(posedge clk);
		check("dieCool", 9'({dieOff, functionsEn}), 9'h001);
		tally_and_finish();
	end
endmodule

`default_nettype wire
